// File: rtl/mmsq_sequencer.sv
// Purpose: host sequencer for a 3-axis magnetic sensor on a two-wire bus
// Assumes: apb slave with one wait state, device interrupt pin active high
// Notes:   results are raw codes; offset procedure yields field and offset
// Function
// - address device 0110000, write bit first
// - measure control sits at pointer 00001000
// - status read: pointer 00000111, then repeated start
// - poll status until bit 0 set
// - interrupt pin may replace status polling
// - results read from pointer 00000000
// - ack all bytes but last, nack, stop
// - SET, measure, RESET, measure, half difference
// - offset is half sum of both
// - RESET may be skipped after SET
// - wait 1 ms after SET or RESET
// - wait per bandwidth before reading results
// - wait 5 ms after power valid
`timescale 1ns/1ps
`default_nettype none
module mmsq_sequencer
	import mmsq_pkg::*;
#(
	parameter int T_OP_CYC   = T_OP_US * CLK_PER_US,
	parameter int T_SR_CYC   = T_SR_US * CLK_PER_US,
	parameter int T_TM00_CYC = T_TM00_US * CLK_PER_US,
	parameter int T_TM01_CYC = T_TM01_US * CLK_PER_US,
	parameter int T_TM10_CYC = T_TM10_US * CLK_PER_US,
	parameter int T_TM11_CYC = T_TM11_US * CLK_PER_US
)(
	input  wire logic        pclk,     // 10 MHz clock
	input  wire logic        presetn,  // async reset, low
	input  wire logic [7:0]  paddr,    // apb address
	input  wire logic        psel,     // apb select
	input  wire logic        penable,  // apb access phase
	input  wire logic        pwrite,   // apb direction
	input  wire logic [31:0] pwdata,   // apb write data
	output logic      [31:0] prdata,   // apb read data
	output logic             pready,   // apb ready
	output logic             pslverr,  // apb error, unmapped
	output logic             scl_o,    // link clock level
	output logic             scl_oe,   // link clock drive
	output logic             sda_o,    // data level when driven
	output logic             sda_oe,   // data pulled low
	input  wire logic        sda_i,    // data pin level
	input  wire logic        int_i     // device interrupt pin
);
	typedef enum {S_PWR, S_IDLE, S_TRIG, S_WAIT, S_POLL, S_INTW, S_FETCH, S_NEXT} mmsq_st_t;
	typedef enum {T_IDLE, T_START, T_ADDRW, T_PTR, T_DATA, T_RSTART, T_ADDRR, T_READ,
		T_STOP} mmsq_tst_t;

	mmsq_st_t          s_st_r;
	mmsq_tst_t         t_st_r;
	logic [WAIT_W-1:0] wait_cnt_r;
	logic [1:0]        step_r;
	logic              tx_go_r, tx_rd_r, tx_done_r, tx_err_r;
	logic [7:0]        tx_ptr_r, tx_data_r;
	logic [2:0]        tx_n_r, rd_idx_r;
	logic [7:0]        rx_r [0:5];
	logic              eng_go_r, eng_last_r, eng_done, eng_nack;
	mmsq_ecmd_t        eng_cmd_r;
	logic [7:0]        eng_wd_r, eng_rdata;
	mmsq_op_t          mode_r;
	logic [1:0]        bw_r;
	logic              use_int_r, go_r, done_r, nack_r;
	logic              i1_r, i2_r, i3_r, int_q_r;
	logic              pready_r, pslverr_r;
	logic [31:0]       prdata_r, rd_mux;
	logic [15:0]       fld_r [0:2];
	logic [15:0]       ofs_r [0:2];
	logic [15:0]       m1_r  [0:2];
	logic [15:0]       raw_w [0:2];
	logic [16:0]       dif_w [0:2];
	logic [16:0]       sum_w [0:2];
	logic              wr_fire, rd_cyc, mapped;

	function automatic logic [WAIT_W-1:0] tm_cyc(input logic [1:0] bw);
		unique case (bw)
			2'h0: tm_cyc = WAIT_W'(T_TM00_CYC);
			2'h1: tm_cyc = WAIT_W'(T_TM01_CYC);
			2'h2: tm_cyc = WAIT_W'(T_TM10_CYC);
			2'h3: tm_cyc = WAIT_W'(T_TM11_CYC);
		endcase
	endfunction : tm_cyc

	// offset procedure steps: SET, measure, RESET, measure
	function automatic logic [7:0] act_byte(input mmsq_op_t m, input logic [1:0] st);
		unique case (m)
			OP_MEAS:  act_byte = CMD_MEAS;
			OP_SET:   act_byte = CMD_SET;
			OP_RESET: act_byte = CMD_RESET;
			OP_PROC:  act_byte = st[0] ? CMD_MEAS : (st[1] ? CMD_RESET : CMD_SET);
		endcase
	endfunction : act_byte

	mmsq_i2c_byte u_eng (
		.pclk    (pclk),
		.presetn (presetn),
		.go      (eng_go_r),
		.cmd     (eng_cmd_r),
		.wdata   (eng_wd_r),
		.last    (eng_last_r),
		.done    (eng_done),
		.rdata   (eng_rdata),
		.nack    (eng_nack),
		.scl_o   (scl_o),
		.scl_oe  (scl_oe),
		.sda_o   (sda_o),
		.sda_oe  (sda_oe),
		.sda_i   (sda_i)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			i1_r    <= 1'b0;
			i2_r    <= 1'b0;
			i3_r    <= 1'b0;
			int_q_r <= 1'b0;
		end else begin
			i1_r <= int_i;
			i2_r <= i1_r;
			i3_r <= i2_r;
			if (i2_r == i3_r)
				int_q_r <= i3_r;
		end
	end

	// sequencing of actions, waits and polling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_st_r     <= S_PWR;
			wait_cnt_r <= WAIT_W'(T_OP_CYC);
			step_r     <= '0;
			tx_go_r    <= 1'b0;
			tx_rd_r    <= 1'b0;
			tx_ptr_r   <= '0;
			tx_data_r  <= '0;
			tx_n_r     <= '0;
		end else begin
			tx_go_r <= 1'b0;
			unique case (s_st_r)
				S_PWR: if (wait_cnt_r != '0)
					wait_cnt_r <= wait_cnt_r - 1'b1;
				else
					s_st_r <= S_IDLE;
				S_IDLE: if (go_r) begin
					step_r    <= '0;
					tx_go_r   <= 1'b1;
					tx_rd_r   <= 1'b0;
					tx_ptr_r  <= PTR_CTRL;
					tx_data_r <= act_byte(mode_r, 2'h0);
					s_st_r    <= S_TRIG;
				end
				S_TRIG: if (tx_done_r) begin
					if (tx_err_r)
						s_st_r <= S_IDLE;
					else begin
						wait_cnt_r <= (tx_data_r == CMD_MEAS) ? tm_cyc(bw_r)
							: WAIT_W'(T_SR_CYC);
						s_st_r <= S_WAIT;
					end
				end
				S_WAIT: if (wait_cnt_r != '0)
					wait_cnt_r <= wait_cnt_r - 1'b1;
				else if (tx_data_r != CMD_MEAS)
					s_st_r <= S_NEXT;
				else if (use_int_r)
					s_st_r <= S_INTW;
				else begin
					tx_go_r  <= 1'b1;
					tx_rd_r  <= 1'b1;
					tx_ptr_r <= PTR_STATUS;
					tx_n_r   <= STAT_BYTES;
					s_st_r   <= S_POLL;
				end
				S_INTW: if (int_q_r) begin
					tx_go_r  <= 1'b1;
					tx_rd_r  <= 1'b1;
					tx_ptr_r <= PTR_OUT;
					tx_n_r   <= OUT_BYTES;
					s_st_r   <= S_FETCH;
				end
				S_POLL: if (tx_done_r) begin
					tx_go_r <= !tx_err_r;
					if (tx_err_r)
						s_st_r <= S_IDLE;
					else if (rx_r[0][STAT_DONE_BIT]) begin
						tx_ptr_r <= PTR_OUT;
						tx_n_r   <= OUT_BYTES;
						s_st_r   <= S_FETCH;
					end
				end
				S_FETCH: if (tx_done_r)
					s_st_r <= tx_err_r ? S_IDLE : S_NEXT;
				S_NEXT: if (mode_r == OP_PROC && step_r != 2'h3) begin
					step_r    <= step_r + 1'b1;
					tx_go_r   <= 1'b1;
					tx_rd_r   <= 1'b0;
					tx_ptr_r  <= PTR_CTRL;
					tx_data_r <= act_byte(mode_r, step_r + 1'b1);
					s_st_r    <= S_TRIG;
				end else
					s_st_r <= S_IDLE;
			endcase
		end
	end

	// one register transaction: write pointer, then data or a read burst
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t_st_r     <= T_IDLE;
			eng_go_r   <= 1'b0;
			eng_cmd_r  <= EC_START;
			eng_wd_r   <= '0;
			eng_last_r <= 1'b0;
			rd_idx_r   <= '0;
			tx_done_r  <= 1'b0;
			tx_err_r   <= 1'b0;
			for (int i = 0; i < 6; i++)
				rx_r[i] <= '0;
		end else begin
			eng_go_r  <= 1'b0;
			tx_done_r <= 1'b0;
			unique case (t_st_r)
				T_IDLE: if (tx_go_r) begin
					tx_err_r  <= 1'b0;
					eng_go_r  <= 1'b1;
					eng_cmd_r <= EC_START;
					t_st_r    <= T_START;
				end
				T_START, T_RSTART: if (eng_done) begin
					eng_go_r  <= 1'b1;
					eng_cmd_r <= EC_WR;
					eng_wd_r  <= {DEV_ADDR, t_st_r == T_RSTART};
					t_st_r    <= (t_st_r == T_RSTART) ? T_ADDRR : T_ADDRW;
				end
				T_ADDRW, T_PTR, T_DATA, T_ADDRR: if (eng_done) begin
					eng_go_r <= 1'b1;
					if (eng_nack || t_st_r == T_DATA) begin
						tx_err_r  <= eng_nack;
						eng_cmd_r <= EC_STOP;
						t_st_r    <= T_STOP;
					end else if (t_st_r == T_ADDRW) begin
						eng_cmd_r <= EC_WR;
						eng_wd_r  <= tx_ptr_r;
						t_st_r    <= T_PTR;
					end else if (t_st_r == T_ADDRR) begin
						eng_cmd_r  <= EC_RD;
						eng_last_r <= (tx_n_r == 3'h1);
						rd_idx_r   <= '0;
						t_st_r     <= T_READ;
					end else if (tx_rd_r) begin
						eng_cmd_r <= EC_START;
						t_st_r    <= T_RSTART;
					end else begin
						eng_cmd_r <= EC_WR;
						eng_wd_r  <= tx_data_r;
						t_st_r    <= T_DATA;
					end
				end
				T_READ: if (eng_done) begin
					rx_r[rd_idx_r] <= eng_rdata;
					eng_go_r       <= 1'b1;
					if (eng_last_r) begin
						eng_cmd_r <= EC_STOP;
						t_st_r    <= T_STOP;
					end else begin
						rd_idx_r   <= rd_idx_r + 1'b1;
						eng_last_r <= (3'(rd_idx_r + 3'h2) == tx_n_r);
					end
				end
				T_STOP: if (eng_done) begin
					tx_done_r <= 1'b1;
					t_st_r    <= T_IDLE;
				end
			endcase
		end
	end

	generate
		for (genvar a = 0; a < 3; a++) begin : g_axis
			assign raw_w[a] = {rx_r[2*a+1], rx_r[2*a]};
			assign dif_w[a] = {1'b0, m1_r[a]} - {1'b0, raw_w[a]};
			assign sum_w[a] = {1'b0, m1_r[a]} + {1'b0, raw_w[a]};
		end
	endgenerate

	// results: raw codes, or half difference and half sum after the procedure
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int a = 0; a < 3; a++) begin
				fld_r[a] <= '0;
				ofs_r[a] <= '0;
				m1_r[a]  <= '0;
			end
		end else if (s_st_r == S_FETCH && tx_done_r && !tx_err_r) begin
			for (int a = 0; a < 3; a++) begin
				if (mode_r != OP_PROC)
					fld_r[a] <= raw_w[a];
				else if (step_r == 2'h1)
					m1_r[a] <= raw_w[a];
				else begin
					fld_r[a] <= dif_w[a][16:1];
					ofs_r[a] <= sum_w[a][16:1];
				end
			end
		end
	end

	// apb slave, one wait state on every access
	assign wr_fire = psel && penable && pready_r && pwrite;
	assign rd_cyc  = psel && penable && !pready_r;
	assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= A_LAST);

	always_comb begin
		rd_mux = '0;
		if (paddr == A_CTRL)
			rd_mux = {26'h0, use_int_r, bw_r, mode_r, 1'b0};
		else if (paddr == A_STAT)
			rd_mux = {28'h0, s_st_r != S_PWR, nack_r, done_r, s_st_r != S_IDLE};
		else if (paddr >= A_FIELD && paddr <= A_LAST)
			rd_mux = (paddr[5:2] < 4'h5) ? {16'h0, fld_r[paddr[3:2] - 2'h2]}
				: {16'h0, ofs_r[2'(paddr[4:2] - 3'h5)]};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= '0;
		end else begin
			pready_r  <= rd_cyc;
			pslverr_r <= rd_cyc && !mapped;
			prdata_r  <= (rd_cyc && mapped && !pwrite) ? rd_mux : '0;
		end
	end

	// control fields only change while idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r    <= MODE_RST;
			bw_r      <= BW_RST;
			use_int_r <= 1'b0;
			go_r      <= 1'b0;
		end else begin
			go_r <= 1'b0;
			if (wr_fire && paddr == A_CTRL && s_st_r == S_IDLE) begin
				mode_r    <= mmsq_op_t'(pwdata[C_MODE +: 2]);
				bw_r      <= pwdata[C_BW +: 2];
				use_int_r <= pwdata[C_USE_INT];
				go_r      <= pwdata[C_GO];
			end
		end
	end

	// sticky flags, write one to clear, a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
			nack_r <= 1'b0;
		end else begin
			done_r <= (done_r && !(wr_fire && paddr == A_STAT && pwdata[S_DONE]))
				|| (s_st_r == S_NEXT && !(mode_r == OP_PROC && step_r != 2'h3));
			nack_r <= (nack_r && !(wr_fire && paddr == A_STAT && pwdata[S_NACK]))
				|| (tx_done_r && tx_err_r);
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	addr_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		eng_go_r && t_st_r == T_ADDRW |-> eng_wd_r == {DEV_ADDR, 1'b0} && eng_cmd_r == EC_WR)
		else $error("device address byte wrong");
	ctrl_ptr_a: assert property (@(posedge pclk) disable iff (!presetn)
		eng_go_r && t_st_r == T_PTR && (s_st_r == S_TRIG) |-> eng_wd_r == PTR_CTRL)
		else $error("control pointer wrong");
	stat_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		t_st_r == T_PTR && eng_done && !eng_nack && s_st_r == S_POLL
		|=> eng_cmd_r == EC_START && t_st_r == T_RSTART)
		else $error("status read lacks repeated start");
	out_ptr_a: assert property (@(posedge pclk) disable iff (!presetn)
		eng_go_r && t_st_r == T_PTR && s_st_r == S_FETCH |-> eng_wd_r == PTR_OUT)
		else $error("result pointer wrong");
	poll_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_st_r == S_POLL ##1 s_st_r == S_FETCH |-> $past(rx_r[0][STAT_DONE_BIT]))
		else $error("fetch without done flag");
	int_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_st_r == S_INTW ##1 s_st_r == S_FETCH |-> $past(int_q_r))
		else $error("fetch without interrupt");
	last_nack_a: assert property (@(posedge pclk) disable iff (!presetn)
		t_st_r == T_READ && eng_done |-> eng_last_r == (3'(rd_idx_r + 3'h1) == tx_n_r))
		else $error("nack not on last byte");
	sr_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_st_r == S_TRIG && tx_done_r && !tx_err_r && tx_data_r != CMD_MEAS
		|=> s_st_r == S_WAIT && wait_cnt_r == WAIT_W'(T_SR_CYC))
		else $error("set or reset wait wrong");
	tm_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_st_r == S_TRIG && tx_done_r && !tx_err_r && tx_data_r == CMD_MEAS
		|=> wait_cnt_r == tm_cyc(bw_r))
		else $error("measure wait wrong");
	pwr_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_st_r == S_PWR |-> !eng_go_r && !tx_go_r)
		else $error("link used before power-up wait");
	proc_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_go_r && s_st_r == S_TRIG && mode_r == OP_PROC |-> tx_data_r == act_byte(OP_PROC, step_r))
		else $error("procedure order wrong");

	meas_c: cover property (@(posedge pclk) disable iff (!presetn)
		s_st_r == S_FETCH && tx_done_r && !tx_err_r);
	proc_c: cover property (@(posedge pclk) disable iff (!presetn)
		mode_r == OP_PROC && step_r == 2'h3 && s_st_r == S_NEXT);
	nack_c: cover property (@(posedge pclk) disable iff (!presetn) tx_done_r && tx_err_r);
	int_c: cover property (@(posedge pclk) disable iff (!presetn)
		s_st_r == S_INTW && int_q_r);
endmodule : mmsq_sequencer
`default_nettype wire

// File: rtl/mmsq_pkg.sv
// Purpose: shared constants and types of the magnetic measure sequencer host
// Assumes: 10 MHz pclk, link clock made here by a divider
// Notes:   times are kept in microseconds, cycle counts derive from them
package mmsq_pkg;
	localparam int CLK_HZ     = 10_000_000;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	localparam int I2C_HZ     = 100_000;
	localparam int QDIV       = CLK_HZ / (4 * I2C_HZ);
	localparam int DIV_W      = 8;
	localparam int WAIT_W     = 20;

	// least waits, microseconds
	localparam int T_OP_US   = 5000;
	localparam int T_SR_US   = 1000;
	localparam int T_TM00_US = 10000;
	localparam int T_TM01_US = 5000;
	localparam int T_TM10_US = 2500;
	localparam int T_TM11_US = 1600;

	// far device
	localparam logic [6:0] DEV_ADDR      = 7'h30;
	localparam logic [7:0] PTR_OUT       = 8'h00;
	localparam logic [7:0] PTR_STATUS    = 8'h07;
	localparam logic [7:0] PTR_CTRL      = 8'h08;
	localparam logic [7:0] CMD_MEAS      = 8'h01;
	localparam logic [7:0] CMD_SET       = 8'h08;
	localparam logic [7:0] CMD_RESET     = 8'h10;
	localparam int         STAT_DONE_BIT = 0;
	localparam logic [2:0] OUT_BYTES     = 3'h6;
	localparam logic [2:0] STAT_BYTES    = 3'h1;

	// own apb map
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_STAT  = 8'h04;
	localparam logic [7:0] A_FIELD = 8'h08;
	localparam logic [7:0] A_LAST  = 8'h1c;
	localparam int C_GO      = 0;
	localparam int C_MODE    = 1;
	localparam int C_BW      = 3;
	localparam int C_USE_INT = 5;
	localparam int S_BUSY    = 0;
	localparam int S_DONE    = 1;
	localparam int S_NACK    = 2;
	localparam int S_PWR_OK  = 3;

	typedef enum logic [1:0] {EC_START, EC_STOP, EC_WR, EC_RD} mmsq_ecmd_t;
	typedef enum logic [1:0] {OP_MEAS, OP_SET, OP_RESET, OP_PROC} mmsq_op_t;
	localparam mmsq_op_t MODE_RST = OP_MEAS;
	localparam logic [1:0] BW_RST = 2'h0;
endpackage : mmsq_pkg

// File: rtl/mmsq_i2c_byte.sv
// Purpose: bit engine: start, stop, byte write with ack read, byte read with ack send
// Assumes: scl made here, no clock stretching by the device
// Notes:   sda is open drain; scl is driven push-pull
`timescale 1ns/1ps
`default_nettype none
module mmsq_i2c_byte
	import mmsq_pkg::*;
(
	input  wire logic       pclk,      // system clock
	input  wire logic       presetn,   // async reset, low
	input  wire logic       go,        // one-cycle command strobe
	input  wire mmsq_ecmd_t cmd,       // command kind
	input  wire logic [7:0] wdata,     // byte to write
	input  wire logic       last,      // read: send nack
	output logic            done,      // one-cycle completion
	output logic [7:0]      rdata,     // byte read
	output logic            nack,      // ninth bit seen high
	output logic            scl_o,     // scl level
	output logic            scl_oe,    // scl drive enable
	output logic            sda_o,     // sda level when driven
	output logic            sda_oe,    // sda pulled low
	input  wire logic       sda_i      // sda pin level
);
	typedef enum {E_IDLE, E_START, E_STOP, E_BIT} mmsq_est_t;
	mmsq_est_t        e_st_r;
	logic [DIV_W-1:0] div_r;
	logic             tick_r;
	logic [1:0]       ph_r;
	logic [3:0]       bit_r;
	logic [8:0]       tx_sh_r;
	logic [8:0]       drv_sh_r;
	logic [8:0]       rx_sh_r;
	logic             s1_r, s2_r, s3_r, sda_q_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else if (div_r == DIV_W'(QDIV - 1)) begin
			div_r  <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r  <= div_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	// three-stage sync, value moves only when the last two agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r    <= 1'b1;
			s2_r    <= 1'b1;
			s3_r    <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			s1_r <= sda_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				sda_q_r <= s3_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			e_st_r   <= E_IDLE;
			ph_r     <= '0;
			bit_r    <= '0;
			tx_sh_r  <= '0;
			drv_sh_r <= '0;
			rx_sh_r  <= '0;
			done     <= 1'b0;
			rdata    <= '0;
			nack     <= 1'b0;
			scl_o    <= 1'b1;
			scl_oe   <= 1'b1;
			sda_o    <= 1'b0;
			sda_oe   <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (e_st_r)
				E_IDLE: if (go) begin
					ph_r  <= '0;
					bit_r <= '0;
					unique case (cmd)
						EC_START: e_st_r <= E_START;
						EC_STOP:  e_st_r <= E_STOP;
						EC_WR: begin
							e_st_r   <= E_BIT;
							tx_sh_r  <= {wdata, 1'b1};
							drv_sh_r <= 9'h1fe;
						end
						EC_RD: begin
							e_st_r   <= E_BIT;
							tx_sh_r  <= {8'hff, last};
							drv_sh_r <= 9'h001;
						end
					endcase
				end
				E_START: if (tick_r) begin
					ph_r <= ph_r + 1'b1;
					unique case (ph_r)
						2'h0: sda_oe <= 1'b0;
						2'h1: scl_o <= 1'b1;
						2'h2: sda_oe <= 1'b1;
						2'h3: begin
							scl_o  <= 1'b0;
							done   <= 1'b1;
							e_st_r <= E_IDLE;
						end
					endcase
				end
				E_STOP: if (tick_r) begin
					ph_r <= ph_r + 1'b1;
					unique case (ph_r)
						2'h0: sda_oe <= 1'b1;
						2'h1: scl_o <= 1'b1;
						2'h2: sda_oe <= 1'b0;
						2'h3: begin
							done   <= 1'b1;
							e_st_r <= E_IDLE;
						end
					endcase
				end
				E_BIT: if (tick_r) begin
					ph_r <= ph_r + 1'b1;
					unique case (ph_r)
						2'h0: sda_oe <= drv_sh_r[8] & ~tx_sh_r[8];
						2'h1: scl_o <= 1'b1;
						2'h2: rx_sh_r <= {rx_sh_r[7:0], sda_q_r};
						2'h3: begin
							scl_o    <= 1'b0;
							tx_sh_r  <= {tx_sh_r[7:0], 1'b1};
							drv_sh_r <= {drv_sh_r[7:0], 1'b0};
							bit_r    <= bit_r + 1'b1;
							if (bit_r == 4'h8) begin
								done   <= 1'b1;
								rdata  <= rx_sh_r[8:1];
								nack   <= rx_sh_r[0];
								e_st_r <= E_IDLE;
							end
						end
					endcase
				end
			endcase
		end
	end
endmodule : mmsq_i2c_byte
`default_nettype wire

// File: test/mmsq_dev_model.sv
// Purpose: far-side sensor model on the two-wire bus
// Assumes: scl push-pull, sda pulled up
// Notes:   field = offset +/- axis value by polarity
`timescale 1ns/1ps
`default_nettype none
module mmsq_dev_model #(
	parameter logic [15:0] OFS     = 16'h4000,
	parameter logic [47:0] HV      = 48'h0,
	parameter int          MEAS_NS = 20000,
	parameter int          SR_NS   = 10000
)(
	input  wire logic scl,    // link clock
	input  wire logic sda,    // data wire
	input  wire logic mute,   // refuse address
	output logic      dev_oe, // pulls sda low
	output logic      int_o   // result ready
);
	logic [7:0]  sh, ptr, rb;
	logic [15:0] v;
	logic        act = 0, adr, rd, first, pol = 1, done = 0, ack_ok, tm_arm = 0;
	int          n = 0, nburst = 0, viol = 0;
	realtime     t_sr = -1.0e9;
	realtime     t_tm = 0.0, gap = 0.0;
	initial begin
		dev_oe = 0;
		int_o = 0;
	end
	task automatic cmd(input logic [7:0] c);
		if (ptr == 8'h08 && c == 8'h01) begin
			done = 0;
			int_o = 0;
			t_tm = $realtime;
			tm_arm = 1;
			fork
				#(MEAS_NS) {done, int_o} = 2'b11;
			join_none
		end
		if (ptr == 8'h08 && c[4:3] != 2'b00) begin
			pol = c[3];
			t_sr = $realtime;
		end
		ptr++;
	endtask : cmd
	always @(negedge sda) if (scl === 1'b1) begin
		if ($realtime - t_sr < SR_NS) viol++;
		// first start after a trigger: how long the host left the device alone
		if (tm_arm) begin
			gap = $realtime - t_tm;
			tm_arm = 0;
		end
		act = 1;
		adr = 1;
		// stale read direction would drive the next address byte
		rd = 0;
		first = 1;
		n = 0;
		dev_oe = 0;
	end
	always @(posedge sda) if (scl === 1'b1) begin
		act = 0;
		dev_oe = 0;
	end
	always @(posedge scl) if (act) begin
		n++;
		if (n <= 8) sh = {sh[6:0], sda};
		else ack_ok = !sda;
	end
	always @(negedge scl) if (act) begin
		if (n == 8 && adr) begin
			adr = 0;
			rd = sh[0];
			act = sh[7:1] == 7'h30 && !mute;
			dev_oe = act;
			nburst = 0;
		end else if (n == 8) begin
			dev_oe = !rd;
			if (!rd && !first) cmd(sh);
			if (!rd && first) ptr = sh;
			first = 0;
		end else if (n == 9) begin
			n = 0;
			act = !rd || ack_ok;
			if (rd && ack_ok) begin
				v = pol ? OFS + HV[16*ptr[2:1] +: 16] : OFS - HV[16*ptr[2:1] +: 16];
				rb = ptr == 8'h07 ? {7'h0, done} : ptr > 8'h05 ? 8'h00 :
					ptr[0] ? v[15:8] : v[7:0];
				ptr++;
				nburst++;
			end
			dev_oe = rd && ack_ok && !rb[7];
		end else if (rd) dev_oe = n < 8 && !rb[7-n];
	end
endmodule : mmsq_dev_model
`default_nettype wire

// File: test/tb_top.sv
// Purpose: self-checking bench of the sequencer over apb
// Assumes: short wait parameters, sensor model on the far side
// Notes:   expected fields follow the model's offset and axis values
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mmsq_pkg::*;
	localparam logic [15:0] OFS = 16'h4000;
	localparam logic [47:0] HV  = 48'h0789_0456_0123;
	logic        pclk, presetn, psel, penable, pwrite, mute, re;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rq;
	logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, dev_oe, int_w;
	wire logic   sda = !(sda_oe || dev_oe);
	wire logic   scl = scl_oe ? scl_o : 1'b1;
	int          fail_count = 0, cmp_count = 0, cyc = 0, t0;
	// bandwidth 11 keeps its real wait so the default timing is exercised once
	int          tm [4] = '{250, 200, 150, T_TM11_US * CLK_PER_US};
	mmsq_sequencer #(.T_OP_CYC(200), .T_SR_CYC(100), .T_TM00_CYC(250), .T_TM01_CYC(200),
		.T_TM10_CYC(150)) u_dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_o(sda_o), .sda_oe(sda_oe), .sda_i(sda), .int_i(int_w));
	mmsq_dev_model #(.OFS(OFS), .HV(HV)) u_dev (.scl(scl), .sda(sda), .mute(mute),
		.dev_oe(dev_oe), .int_o(int_w));
	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
		re = pslverr;
		rq = prdata;
		chk("apb_ready", 1, k < 20);
		if (k == 20) wrap_up;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic go(input logic [1:0] m, input logic [1:0] b, input logic ui);
		int k;
		apb(1, A_CTRL, {26'h0, ui, b, m, 1'b1});
		t0 = cyc;
		for (k = 0; k < 20000; k++) begin
			apb(0, A_STAT, 0);
			if (rq[S_BUSY] === 1'b0) break;
		end
		if (k == 20000) begin
			fail_count++;
			wrap_up;
		end
	endtask : go
	initial begin
		{presetn, psel, penable, pwrite, mute, paddr, pwdata} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		apb(1, A_CTRL, 32'h1);
		apb(0, A_STAT, 0);
		chk("pwr_ok", 0, rq[S_PWR_OK]);
		repeat (250) @(posedge pclk);
		apb(0, A_STAT, 0);
		chk("stat_idle", 32'h8, rq);
		chk("pin_idle", 32'h1, {sda_o, scl_oe});
		apb(0, 8'h20, 0);
		chk("slverr", 1, re);
		chk("unmapped", 0, rq);
		go(1, 0, 0);
		for (int b = 0; b < 4; b++) begin
			go(0, b[1:0], b[0]);
			chk("tm_wait", 1, cyc - t0 >= tm[b]);
			chk("tm_gap", 1, u_dev.gap >= 100.0 * tm[b]);
			chk("burst", 6, u_dev.nburst);
			apb(0, A_STAT, 0);
			chk("done", 32'ha, rq);
			apb(1, A_STAT, 32'h2);
			for (int a = 0; a < 3; a++) begin
				apb(0, A_FIELD + 8'(4 * a), 0);
				chk("field", {16'h0, OFS + HV[16*a +: 16]}, rq);
			end
		end
		go(2, 0, 0);
		go(3, 0, 0);
		for (int a = 0; a < 6; a++) begin
			apb(0, A_FIELD + 8'(4 * a), 0);
			chk("proc", {16'h0, a < 3 ? HV[16*(a%3) +: 16] : OFS}, rq);
		end
		chk("sr_gap", 0, u_dev.viol);
		apb(1, A_STAT, 32'h6);
		mute <= 1;
		go(0, 0, 0);
		apb(0, A_STAT, 0);
		chk("nack", 1, rq[S_NACK]);
		apb(1, A_STAT, 32'h6);
		apb(0, A_STAT, 0);
		chk("w1c", 0, rq[2:1]);
		wrap_up;
	end
endmodule : tb_top
`default_nettype wire
